// ### bench/ipsp_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// far side pulse port: sends pulses, watches the device's driver
// ****************
module ipsp_peer import ipsp_pkg::*; (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // sync reset
    input wire logic go_i, // send one pulse
    input wire logic lng_i, // long pulse
    input wire logic pos_i, // +1 pulse
    output logic pos_o, // to positive comparator
    output logic neg_o, // to negative comparator
    input wire logic rx_pos_i, // watched positive drive
    input wire logic rx_oe_i, // watched driver on
    output ipsp_pulse_t seen_o, // last pulse seen, vld low if badly timed
    output logic [7:0] seen_cnt_o // pulses seen
);
    logic [2:0] left;
    logic lng;
    logic sgn;
    logic [2:0] wid;
    logic fst;
    logic oe_q;
    wire logic act = left != 3'h0;
    wire logic lead = lng ? left > 3'h2 : left > 3'h1;
    // a released pair rests at 0V, so both comparators read low
    assign pos_o = act && (lead == sgn);
    assign neg_o = act && (lead != sgn);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left <= 3'h0;
        end else if (go_i && !act) begin
            left <= lng_i ? 3'h4 : 3'h2;
            lng <= lng_i;
            sgn <= pos_i;
        end else if (act) begin
            left <= left - 3'h1;
        end
    end
    // only pulses with the driver on for 4 or 2 cycles in all count as valid; the halves are not checked
    always_ff @(posedge clk_i) begin
        oe_q <= rx_oe_i && !rst_i;
        wid <= rx_oe_i ? (oe_q ? wid + 3'h1 : 3'h1) : wid;
        fst <= (rx_oe_i && !oe_q) ? rx_pos_i : fst;
        if (rst_i) begin
            seen_o <= '0;
            seen_cnt_o <= 8'h00;
        end else if (oe_q && !rx_oe_i) begin
            seen_o <= '{vld: wid == 3'h4 || wid == 3'h2, lng: wid == 3'h4, pos: fst};
            seen_cnt_o <= seen_cnt_o + 8'h01;
        end
    end
endmodule : ipsp_peer
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// pulse mode, reversal, idle, then spi mode
// ****************
module testbench import ipsp_pkg::*;;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sck = 1'b1;
    logic mode = 1'b1;
    logic cs_n = 1'b1;
    logic serial_data_in = 1'b0;
    logic rd_act = 1'b0;
    logic rd_bit = 1'b1;
    logic ga = 1'b0;
    logic gb = 1'b0;
    logic lng = 1'b0;
    logic pos = 1'b0;
    wire logic ap, an, bp, bn, a_dp, b_dp, ao, bo, sdo_oe, slave_b;
    wire ipsp_spi_t spi;
    wire ipsp_state_t st;
    wire ipsp_pulse_t sb;
    wire logic [7:0] na, nb;
    wire logic [15:0] cmd;
    int errors = 0;
    int total_checks = 0;
    int nsck = 0;
    always #50 clk = ~clk;
    // counted mid-cycle so the launching edge cannot race the count
    always @(negedge clk) if (spi.sck === 1'b1) nsck++;
    ipsp_port #(.IDLE_CYC(200)) ipsp_port_i (.sys_clk_i(clk), .srst_i(srst), .spi_sck_i(sck),
        .port_mode_select_i(mode), .chip_select_n_i(cs_n), .serial_data_in_i(serial_data_in),
        .serial_data_out_o(), .serial_data_out_oe_o(sdo_oe), .port_a_pos_i(ap),
        .port_a_neg_i(an), .port_a_pos_o(a_dp), .port_a_neg_o(), .port_a_oe_o(ao),
        .port_b_pos_i(bp), .port_b_neg_i(bn), .port_b_pos_o(b_dp), .port_b_neg_o(),
        .port_b_oe_o(bo), .core_standby_i(1'b1), .int_read_active_i(rd_act),
        .int_read_bit_i(rd_bit), .int_spi_o(spi), .cmd_o(cmd), .cmd_ok_o(), .wr_data_o(),
        .wr_commit_o(), .state_o(st), .slave_b_o(slave_b));
    ipsp_peer ipsp_peer_a_i (.clk_i(clk), .rst_i(srst), .go_i(ga), .lng_i(lng), .pos_i(pos),
        .pos_o(ap), .neg_o(an), .rx_pos_i(a_dp), .rx_oe_i(ao), .seen_o(), .seen_cnt_o(na));
    ipsp_peer ipsp_peer_b_i (.clk_i(clk), .rst_i(srst), .go_i(gb), .lng_i(lng), .pos_i(pos),
        .pos_o(bp), .neg_o(bn), .rx_pos_i(b_dp), .rx_oe_i(bo), .seen_o(sb), .seen_cnt_o(nb));
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // one pulse from a far side; later events stay well over 6 cycles apart
    task automatic send(input logic on_b, input logic l, input logic p);
        ga <= !on_b;
        gb <= on_b;
        lng <= l;
        pos <= p;
        tick(1);
        ga <= 1'b0;
        gb <= 1'b0;
        tick(12);
    endtask : send
    task automatic wait_b(input logic [7:0] n0, input logic [2:0] e);
        int i;
        for (i = 0; i < 80 && nb == n0; i++) @(posedge clk);
        if (nb == n0) begin
            errors++;
            wrap_up();
        end
        chk(16'(sb), 16'(e));
    endtask : wait_b
    task automatic wait_st(input ipsp_state_t s, input int lim, output int n);
        for (n = 0; n < lim && st !== s; n++) @(posedge clk);
        if (st !== s) begin
            errors++;
            wrap_up();
        end
    endtask : wait_st
    task automatic s_wake;
        int n;
        logic [7:0] n0;
        n0 = nb;
        send(1'b0, 1'b1, 1'b0);
        wait_st(ST_READY, 300, n);
        chk(16'(n >= 70 && n <= 110), 16'h1);
        wait_b(n0, 3'b111);
    endtask : s_wake
    task automatic s_fwd;
        int k;
        logic [7:0] n0;
        n0 = nb;
        send(1'b0, 1'b1, 1'b0);
        wait_b(n0, 3'b110);
        chk({14'h0, st}, {14'h0, ST_ACTIVE});
        chk(16'({slave_b, spi.cs_n}), 16'h0);
        for (int b = 1; b >= 0; b--) begin
            n0 = nb;
            k = nsck;
            send(1'b0, 1'b0, b[0]);
            wait_b(n0, {2'b10, b[0]});
            chk(16'({spi.serial_data_in, nsck == k + 1}), {15'h0, b[0], 1'b1});
        end
        chk(16'(na), 16'h0);
        send(1'b1, 1'b1, 1'b0);
        chk(16'(slave_b), 16'h0);
        tick(25);
        send(1'b1, 1'b1, 1'b0);
        chk(16'(slave_b), 16'h1);
        send(1'b1, 1'b1, 1'b1);
        wait_st(ST_READY, 20, k);
        chk(16'(spi.cs_n), 16'h1);
    endtask : s_fwd
    task automatic spi_bit(input logic d);
        serial_data_in <= d;
        #80 sck <= 1'b0;
        #80 sck <= 1'b1;
        @(posedge clk);
    endtask : spi_bit
    task automatic s_spi;
        int n;
        logic [7:0] n0;
        logic [31:0] cw = 32'h00013d6e;
        srst <= 1'b1;
        mode <= 1'b0;
        tick(5);
        srst <= 1'b0;
        tick(3);
        n0 = nb;
        cs_n <= 1'b0;
        tick(4);
        cs_n <= 1'b1;
        wait_st(ST_READY, 300, n);
        wait_b(n0, 3'b111);
        n0 = nb;
        cs_n <= 1'b0;
        wait_b(n0, 3'b110);
        // command word 0x0001 followed by its known check code
        for (int i = 31; i >= 0; i--) begin
            spi_bit(cw[i]);
            tick(6);
        end
        tick(4);
        chk(cmd, 16'h0001);
        rd_act <= 1'b1;
        for (int b = 1; b >= 0; b--) begin
            n0 = nb;
            rd_bit <= b[0];
            spi_bit(b[0]);
            wait_b(n0, {2'b10, b[0]});
            tick(12);
            chk(16'(sdo_oe), 16'(!b[0]));
        end
        n0 = nb;
        cs_n <= 1'b1;
        wait_b(n0, 3'b111);
        chk(16'(sdo_oe), 16'h0);
    endtask : s_spi
    initial begin
        int n;
        tick(5);
        srst <= 1'b0;
        tick(3);
        s_wake();
        s_fwd();
        wait_st(ST_IDLE, 400, n);
        s_spi();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire

// ### logic/ipsp_pkg.sv
`default_nettype none
package ipsp_pkg;
    localparam int CLK_NS = 100;
    localparam int LONG_HALF_NS = 150;
    localparam int SHORT_HALF_NS = 50;
    localparam int WAKE_DWELL_NS = 240;
    localparam int BLOCK_NS = 2000;
    localparam int WAKE_TIME_NS = 400000;
    localparam int READY_TIME_NS = 10000;
    localparam int IDLE_TIMEOUT_NS = 5500000;
    // least times round up, longest times round down
    localparam logic [1:0] LONG_HALF_CYC = 2'((LONG_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] SHORT_HALF_CYC = 2'((SHORT_HALF_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [1:0] DWELL_CYC = 2'((WAKE_DWELL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] BLOCK_CYC = 8'((BLOCK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] WAKE_CYC = 12'(WAKE_TIME_NS / CLK_NS);
    localparam logic [11:0] READY_CYC = 12'(READY_TIME_NS / CLK_NS);
    localparam logic [3:0] RET_WIN_CYC = 4'h8;
    localparam logic [14:0] PEC_SEED = 15'h0010;
    localparam logic [14:0] PEC_POLY = 15'h4599;
    localparam logic [6:0] POS_CMD_END = 7'h10;
    localparam logic [6:0] POS_CMD_PEC_END = 7'h20;
    localparam logic [6:0] POS_DATA_END = 7'h50;
    localparam logic [6:0] POS_FRAME_END = 7'h60;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAKING = 2'b01,
        ST_READY = 2'b11,
        ST_ACTIVE = 2'b10
    } ipsp_state_t;

    typedef struct packed {
        logic vld;
        logic lng;
        logic pos;
    } ipsp_pulse_t;

    typedef struct packed {
        logic cs_n;
        logic serial_data_in;
        logic sck;
    } ipsp_spi_t;

    function automatic logic [14:0] ipsp_pec_step(input logic [14:0] c, input logic d);
        logic in0;
        in0 = d ^ c[14];
        return {c[13:0], 1'b0} ^ (in0 ? PEC_POLY : 15'h0000);
    endfunction : ipsp_pec_step
endpackage : ipsp_pkg
`default_nettype wire

// ### logic/ipsp_port.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - spi mode: cs and clock edges become long/short pulses on the master port
// - long pulse two 150ns halves, short two 50ns halves, sign gives first level
// - slave pulses rebuild internal chip select, data and clock
// - during a read, a zero bit is answered with short -1 on the slave port
// - slave port sends only short -1 pulses
// - no return pulse in the slot means a one
// - ready, pulse mode: port receiving long -1 becomes slave, other master
// - sleeping device wakes from either port in either mode
// - wake via port A sends long +1 on port B once ready
// - active holds internal cs low; long +1 on slave returns to ready
// - active: long -1 on master after block time swaps roles
// - long pulses on master within block time are ignored
// - after command and check code the read is decoded for the core
// - no activity for idle timeout drops the port to idle
// - spi mode wakes on cs or clock; pulse mode on differential activity
// - wake needs differential level held for the dwell time
// - ready reached after wake time or ready time per core state
// - a wake pulse arriving in ready is not forwarded
// - transfers are whole bytes, most significant bit first
// - write data is committed when chip select rises
// - check code is a 15-bit crc with fixed seed and polynomial
// - sent check code is the remainder with a zero appended
// - a block is acted on only when its check code matches
module ipsp_port import ipsp_pkg::*; #(
    parameter int IDLE_CYC = IDLE_TIMEOUT_NS / CLK_NS // idle timeout in cycles
) (
    input wire logic sys_clk_i, // system clock
    input wire logic srst_i, // synchronous reset
    input wire logic spi_sck_i, // spi clock, link domain
    input wire logic port_mode_select_i, // high: port a is a pulse port
    input wire logic chip_select_n_i, // spi chip select
    input wire logic serial_data_in_i, // spi data in
    output logic serial_data_out_o, // open drain data, always low
    output logic serial_data_out_oe_o, // pulls data out low
    input wire logic port_a_pos_i, // port a positive comparator
    input wire logic port_a_neg_i, // port a negative comparator
    output logic port_a_pos_o, // port a drive positive
    output logic port_a_neg_o, // port a drive negative
    output logic port_a_oe_o, // port a driver on
    input wire logic port_b_pos_i, // port b positive comparator
    input wire logic port_b_neg_i, // port b negative comparator
    output logic port_b_pos_o, // port b drive positive
    output logic port_b_neg_o, // port b drive negative
    output logic port_b_oe_o, // port b driver on
    input wire logic core_standby_i, // core in standby, not sleep
    input wire logic int_read_active_i, // core is shifting out read data
    input wire logic int_read_bit_i, // current read bit of the core
    output ipsp_spi_t int_spi_o, // rebuilt internal serial signals
    output logic [15:0] cmd_o, // last checked command
    output logic cmd_ok_o, // command with matching check code
    output logic [47:0] wr_data_o, // committed write data
    output logic wr_commit_o, // write data committed
    output ipsp_state_t state_o, // port state
    output logic slave_b_o // port b is the slave
);
    // ****************************************
    // link clock domain
    // ****************************************
    logic sck_tgl = 1'b0;
    logic sck_bit = 1'b0;
    always_ff @(posedge spi_sck_i) begin
        if (!chip_select_n_i) begin
            sck_tgl <= ~sck_tgl;
            sck_bit <= serial_data_in_i;
        end
    end

    // ****************************************
    // synchronisers and spi events
    // ****************************************
    logic [2:0] cs_s;
    logic [2:0] tg_s = 3'h0;
    logic [1:0] md_s;
    always_ff @(posedge sys_clk_i) begin
        cs_s <= srst_i ? 3'h7 : {cs_s[1:0], chip_select_n_i};
        tg_s <= {tg_s[1:0], sck_tgl};
        md_s <= {md_s[0], port_mode_select_i};
    end
    wire pulse_mode = md_s[1];
    wire spi_fall = cs_s[2] & ~cs_s[1] & ~pulse_mode;
    wire spi_rise = ~cs_s[2] & cs_s[1] & ~pulse_mode;
    // sck_bit is stable long before the synchronised toggle shows
    wire sck_tick = (tg_s[2] ^ tg_s[1]) & ~pulse_mode & ~srst_i;

    // ****************************************
    // pulse receivers
    // ****************************************
    ipsp_state_t state, next_state;
    logic tx_busy, tx_port, tx_lng, tx_pos, tx_ph;
    logic [1:0] tx_cnt;
    wire [1:0] pin_pos = {port_b_pos_i, port_a_pos_i};
    wire [1:0] pin_neg = {port_b_neg_i, port_a_neg_i};
    ipsp_pulse_t rx_pl [2];
    logic [1:0] dwell_ok;
    for (genvar p = 0; p < 2; p++) begin : g_rx
        logic [1:0] s1, s2, first, lvl;
        logic [2:0] cnt;
        logic [1:0] dwc;
        ipsp_pulse_t rx;
        // a port never listens to its own driver
        assign lvl = (tx_busy && tx_port == p) ? 2'b00 : s2;
        assign rx_pl[p] = rx;
        assign dwell_ok[p] = (dwc == DWELL_CYC);
        always_ff @(posedge sys_clk_i) begin
            s1 <= {pin_pos[p], pin_neg[p]};
            s2 <= s1;
        end
        always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
                first <= 2'b00;
                cnt <= 3'h0;
                dwc <= 2'h0;
                rx <= '0;
            end else begin
                rx.vld <= 1'b0;
                dwc <= (^s2) ? (dwell_ok[p] ? dwc : dwc + 2'h1) : 2'h0;
                if (first == 2'b00) begin
                    if (^lvl) begin
                        first <= lvl;
                        cnt <= 3'h1;
                    end
                end else if (lvl == first) begin
                    if (cnt != 3'h7) begin
                        cnt <= cnt + 3'h1;
                    end
                end else begin
                    first <= 2'b00;
                    rx.vld <= (lvl == ~first);
                    rx.lng <= (cnt >= 3'(LONG_HALF_CYC));
                    rx.pos <= first[1];
                end
            end
        end
    end

    // ****************************************
    // role and event selection
    // ****************************************
    logic slave_b, next_slave_b, wake_a, next_wake_a, swap;
    logic [11:0] wait_cnt;
    logic [15:0] idle_cnt;
    logic [7:0] block_cnt;
    logic [3:0] ret_cnt;
    logic up_zero, sck_pend;
    ipsp_pulse_t req, ev, spi_ev;
    logic req_port;
    wire mst = ~slave_b;
    wire mst_long = rx_pl[mst].vld & rx_pl[mst].lng;
    wire mst_short_neg = rx_pl[mst].vld & ~rx_pl[mst].lng & ~rx_pl[mst].pos;
    wire block_open = (block_cnt == 8'h0) & ~tx_busy;
    assign spi_ev = '{vld: spi_rise | sck_tick, lng: spi_rise, pos: spi_rise | sck_bit};
    assign ev = pulse_mode ? rx_pl[slave_b] : spi_ev;
    wire start_a = pulse_mode ? (rx_pl[0].vld & rx_pl[0].lng & ~rx_pl[0].pos) : spi_fall;
    wire start_b = pulse_mode & rx_pl[1].vld & rx_pl[1].lng & ~rx_pl[1].pos & ~start_a;
    wire wake_on_a = pulse_mode ? dwell_ok[0] : (spi_fall | spi_rise | sck_tick);
    wire wake_any = wake_on_a | dwell_ok[1];
    assign swap = pulse_mode & mst_long & ~rx_pl[mst].pos & block_open;
    wire fwd_short = (state == ST_ACTIVE) & ~swap & ev.vld & ~ev.lng;
    wire ret_fire = (ret_cnt == 4'h1);
    wire ret_zero = up_zero | (int_read_active_i & ~int_read_bit_i);
    wire activity = rx_pl[0].vld | rx_pl[1].vld | (|dwell_ok) | spi_ev.vld | spi_fall;
    wire idle_out = (idle_cnt == 16'h0);

    // ****************************************
    // port state machine
    // ****************************************
    always_comb begin
        next_state = state;
        next_slave_b = slave_b;
        next_wake_a = wake_a;
        req = '0;
        req_port = 1'b0;
        case (state)
            ST_IDLE: begin
                if (wake_any) begin
                    next_state = ST_WAKING;
                    next_wake_a = wake_on_a;
                end
            end
            ST_WAKING: begin
                if (wait_cnt == 12'h0) begin
                    next_state = ST_READY;
                    next_slave_b = 1'b0;
                    req = '{vld: wake_a, lng: 1'b1, pos: 1'b1};
                    req_port = 1'b1;
                end
            end
            ST_READY: begin
                // anything but a start is swallowed here, wake pulses included
                if (start_a | start_b) begin
                    next_state = ST_ACTIVE;
                    next_slave_b = start_b;
                    req = '{vld: 1'b1, lng: 1'b1, pos: 1'b0};
                    req_port = ~start_b;
                end
            end
            ST_ACTIVE: begin
                if (swap) begin
                    next_slave_b = ~slave_b;
                    req = '{vld: 1'b1, lng: 1'b1, pos: 1'b0};
                    req_port = slave_b;
                end else if (ev.vld) begin
                    req = ev;
                    req_port = mst;
                    if (ev.lng && ev.pos) begin
                        next_state = ST_READY;
                    end
                end else if (ret_fire && ret_zero && pulse_mode) begin
                    req = '{vld: 1'b1, lng: 1'b0, pos: 1'b0};
                    req_port = slave_b;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (idle_out && state[1]) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            slave_b <= 1'b0;
            wake_a <= 1'b0;
        end else begin
            state <= next_state;
            slave_b <= next_slave_b;
            wake_a <= next_wake_a;
        end
    end

    // ****************************************
    // timers
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state == ST_IDLE) begin
            wait_cnt <= core_standby_i ? READY_CYC : WAKE_CYC;
        end else if (wait_cnt != 12'h0) begin
            wait_cnt <= wait_cnt - 12'h1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || activity || req.vld || !state[1]) begin
            idle_cnt <= 16'(IDLE_CYC);
        end else if (!idle_out) begin
            idle_cnt <= idle_cnt - 16'h1;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            block_cnt <= 8'h0;
        end else if (tx_busy) begin
            block_cnt <= BLOCK_CYC;
        end else if (block_cnt != 8'h0) begin
            block_cnt <= block_cnt - 8'h1;
        end
    end

    // ****************************************
    // pulse transmitter
    // ****************************************
    // a request made while a pulse is on the wire is dropped; the
    // link rate leaves a gap of several pulse lengths between events
    wire [1:0] half = req.lng ? LONG_HALF_CYC : SHORT_HALF_CYC;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_busy <= 1'b0;
            tx_port <= 1'b0;
            tx_lng <= 1'b0;
            tx_pos <= 1'b0;
            tx_ph <= 1'b0;
            tx_cnt <= 2'h0;
        end else if (!tx_busy) begin
            if (req.vld) begin
                tx_busy <= 1'b1;
                tx_port <= req_port;
                tx_lng <= req.lng;
                tx_pos <= req.pos;
                tx_ph <= 1'b0;
                tx_cnt <= half - 2'h1;
            end
        end else if (tx_cnt != 2'h0) begin
            tx_cnt <= tx_cnt - 2'h1;
        end else if (!tx_ph) begin
            tx_ph <= 1'b1;
            tx_cnt <= (tx_lng ? LONG_HALF_CYC : SHORT_HALF_CYC) - 2'h1;
        end else begin
            tx_busy <= 1'b0;
        end
    end
    wire tx_high = tx_ph ^ tx_pos;
    assign port_a_oe_o = tx_busy & ~tx_port;
    assign port_b_oe_o = tx_busy & tx_port;
    assign port_a_pos_o = port_a_oe_o & tx_high;
    assign port_a_neg_o = port_a_oe_o & ~tx_high;
    assign port_b_pos_o = port_b_oe_o & tx_high;
    assign port_b_neg_o = port_b_oe_o & ~tx_high;

    // ****************************************
    // internal serial port and return slot
    // ****************************************
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            int_spi_o <= '{cs_n: 1'b1, serial_data_in: 1'b0, sck: 1'b0};
            sck_pend <= 1'b0;
            ret_cnt <= 4'h0;
            up_zero <= 1'b0;
            serial_data_out_oe_o <= 1'b0;
        end else begin
            int_spi_o.cs_n <= (next_state != ST_ACTIVE);
            int_spi_o.sck <= sck_pend;
            sck_pend <= fwd_short;
            if (fwd_short) begin
                int_spi_o.serial_data_in <= ev.pos;
            end
            ret_cnt <= fwd_short ? RET_WIN_CYC : (ret_cnt != 4'h0 ? ret_cnt - 4'h1 : 4'h0);
            // a return pulse wins over the clear of a new slot
            up_zero <= (mst_short_neg && ret_cnt != 4'h0) ? 1'b1 : (fwd_short ? 1'b0 : up_zero);
            if (spi_rise || pulse_mode) begin
                serial_data_out_oe_o <= 1'b0;
            end else if (ret_fire) begin
                serial_data_out_oe_o <= ret_zero;
            end
        end
    end
    assign serial_data_out_o = 1'b0;

    // ****************************************
    // framing and check code
    // ****************************************
    logic [6:0] bcnt;
    logic [14:0] crc;
    logic [15:0] sh, cmd_q;
    logic [47:0] wr_q;
    logic wr_ok;
    wire bit_in = int_spi_o.serial_data_in;
    wire in_crc = (bcnt < POS_CMD_END) || (bcnt >= POS_CMD_PEC_END && bcnt < POS_DATA_END);
    wire [15:0] sh_nx = {sh[14:0], bit_in};
    wire pec_match = (sh_nx == {crc, 1'b0});
    wire cs_rise = ~int_spi_o.cs_n & (next_state != ST_ACTIVE);
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cmd_o <= 16'h0;
            cmd_ok_o <= 1'b0;
            wr_data_o <= 48'h0;
            wr_commit_o <= 1'b0;
        end else begin
            cmd_ok_o <= sck_pend && bcnt == POS_CMD_PEC_END - 7'h1 && pec_match;
            if (sck_pend && bcnt == POS_CMD_PEC_END - 7'h1 && pec_match) begin
                cmd_o <= cmd_q;
            end
            wr_commit_o <= cs_rise && wr_ok && bcnt == POS_FRAME_END;
            if (cs_rise && wr_ok && bcnt == POS_FRAME_END) begin
                wr_data_o <= wr_q;
            end
        end
    end
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || int_spi_o.cs_n) begin
            bcnt <= 7'h0;
            crc <= PEC_SEED;
            sh <= 16'h0;
            wr_ok <= 1'b0;
        end else if (sck_pend) begin
            bcnt <= (bcnt == 7'h7f) ? bcnt : bcnt + 7'h1;
            sh <= sh_nx;
            if (in_crc) begin
                crc <= ipsp_pec_step(crc, bit_in);
            end else if (bcnt == POS_CMD_PEC_END - 7'h1) begin
                crc <= PEC_SEED;
            end
            if (bcnt == POS_CMD_END - 7'h1) begin
                cmd_q <= sh_nx;
            end
            if (bcnt >= POS_CMD_PEC_END && bcnt < POS_DATA_END) begin
                wr_q <= {wr_q[46:0], bit_in};
            end
            wr_ok <= (bcnt == POS_FRAME_END - 7'h1) ? pec_match : wr_ok;
        end
    end
    assign state_o = state;
    assign slave_b_o = slave_b;

    // ****************************************
    // checks
    // ****************************************
    a_slave_short_neg: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (tx_busy && tx_port == slave_b && state == ST_ACTIVE && $stable(slave_b))
        |-> (!tx_lng && !tx_pos)) else $error("slave port sent a forbidden pulse");
    a_long_pulse_len: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ($rose(tx_busy) && tx_lng) |-> !tx_ph [*2] ##1 tx_ph [*2] ##1 !tx_busy)
        else $error("long pulse halves wrong length");
    a_short_pulse_len: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ($rose(tx_busy) && !tx_lng) |-> !tx_ph ##1 tx_ph ##1 !tx_busy)
        else $error("short pulse halves wrong length");
    a_active_cs_low: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ($past(state) == ST_ACTIVE && state == ST_ACTIVE) |-> !int_spi_o.cs_n)
        else $error("internal chip select high while active");
    a_block_rejects: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state == ST_ACTIVE && mst_long && !block_open) |=> $stable(slave_b))
        else $error("port swap inside block time");
    a_swap_after_block: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state == ST_ACTIVE && swap && !idle_out) |=> (slave_b != $past(slave_b)) ##1 tx_busy)
        else $error("roles not swapped");
    a_wake_a_fwd_b: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state == ST_WAKING && wait_cnt == 12'h0 && wake_a)
        |=> (tx_busy && tx_port && tx_lng && tx_pos)) else $error("no long +1 on port b");
    a_idle_drop: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state[1] && idle_out) |=> state == ST_IDLE) else $error("idle timeout missed");
    a_dwell_wake: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $rose(dwell_ok[1]) |-> $past(^g_rx[1].s2, 1) && $past(^g_rx[1].s2, 2))
        else $error("wake qualified before dwell");
endmodule : ipsp_port
`default_nettype wire
